// ===== test/control_source_model.sv
// Far-side model: divider pin network and duty control voltage.
// Assumes the bench requests a code and a duty word at any time.
`timescale 1ns/1ns

module control_source_model (
  input  wire logic       clock_in,
  input  wire logic [3:0] code_req_in,
  input  wire logic [9:0] duty_req_in,
  output logic      [3:0] divider_select_code_out,
  output logic      [9:0] duty_command_out
);
  // ==========================================================
  // Converter result follows the pin ratio (code+0.5)/16 exactly.
  // Change off the sampling edge so the core never sees a race;
  // one process drives both, unknown only until the first edge
  always @(negedge clock_in) begin
    divider_select_code_out <= code_req_in;
    duty_command_out        <= duty_req_in;
  end
endmodule : control_source_model

// ===== test/test_divided_pwm_oscillator_core.sv
// Self-checking bench for the divided PWM oscillator core.
// Runs an unclamped and a two-sided clamped core side by side.
`timescale 1ns/1ns

module test_divided_pwm_oscillator_core;
  typedef struct packed {
    logic [3:0]  code;
    logic [9:0]  duty;
    logic [2:0]  ratio;
    logic        inv;
    logic [15:0] high;
    logic [15:0] both;
  } row_type;

  logic        clock_in = 1'b0;
  logic        rst_in   = 1'b1;
  logic [3:0]  code_req = 4'h1;
  logic [9:0]  duty_req = 10'h1f4;
  logic [3:0]  code;
  logic [9:0]  duty;
  logic        pwm;
  logic        pwm_both;
  logic        inv;
  logic [2:0]  ratio;
  logic        started;
  int          error_cnt = 0;
  int          checked   = 0;
  logic [15:0] highs;
  logic [15:0] highs_both;
  row_type     rows [9];

  always #25 clock_in = ~clock_in;

  control_source_model control_source_model_inst (
    .clock_in(clock_in), .code_req_in(code_req), .duty_req_in(duty_req),
    .divider_select_code_out(code), .duty_command_out(duty));

  divided_pwm_oscillator_core divided_pwm_oscillator_core_inst (
    .clock_in(clock_in), .rst_in(rst_in), .divider_select_code_in(code),
    .duty_command_in(duty), .pwm_out(pwm), .output_invert_bit_out(inv),
    .ratio_select_out(ratio), .started_out(started));

  // Two-sided clamp copy shares the inputs; only its duty range differs
  divided_pwm_oscillator_core #(
    .CLAMP(pwm_osc_pkg::CLAMP_BOTH)
  ) divided_pwm_oscillator_core_both_inst (
    .clock_in(clock_in), .rst_in(rst_in), .divider_select_code_in(code),
    .duty_command_in(duty), .pwm_out(pwm_both), .output_invert_bit_out(),
    .ratio_select_out(), .started_out());

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0d seen %0d", name, exp, seen);
    end
  endtask : check

  // Count high cycles over a span; whole periods make it phase-free
  task automatic measure(int span);
    highs      = 16'h0000;
    highs_both = 16'h0000;
    repeat (span) begin
      @(negedge clock_in);
      if (pwm === 1'b1) highs++;
      if (pwm_both === 1'b1) highs_both++;
    end
  endtask : measure

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // Watchdog sized well above the longest expected run
  initial begin
    #(60000 * 50);
    error_cnt++;
    end_of_test();
  end

  initial begin
    int n;
    int i;
    // ==========================================================
    // Rows: code, duty, ratio, invert, highs per period, clamped highs
    rows[0] = {4'h1, 10'h1f4, 3'h1, 1'b0, 16'h0002, 16'h0002};
    rows[1] = {4'h2, 10'h0fa, 3'h2, 1'b0, 16'h0004, 16'h0004};
    rows[2] = {4'h2, 10'h3ff, 3'h2, 1'b0, 16'h0010, 16'h000f};
    rows[3] = {4'h2, 10'h000, 3'h2, 1'b0, 16'h0000, 16'h0001};
    rows[4] = {4'h3, 10'h1f4, 3'h3, 1'b0, 16'h0020, 16'h0020};
    rows[5] = {4'hd, 10'h0fa, 3'h2, 1'b1, 16'h000c, 16'h000c};
    rows[6] = {4'hd, 10'h000, 3'h2, 1'b1, 16'h0010, 16'h000f};
    rows[7] = {4'hf, 10'h1f4, 3'h0, 1'b1, 16'h0001, 16'h0001};
    rows[8] = {4'h0, 10'h3e8, 3'h0, 1'b0, 16'h0001, 16'h0000};
    repeat (8) @(negedge clock_in);
    check("pwm in reset", {15'h0, pwm}, 16'h0);
    rst_in = 1'b0;
    measure(499);
    check("start highs", highs, 16'h0);
    check("started early", {15'h0, started}, 16'h0);
    for (i = 0; i < 200 && started !== 1'b1; i++) @(negedge clock_in);
    check("started", {15'h0, started}, 16'h1);
    for (int r = 0; r < 9; r++) begin
      code_req = rows[r].code;
      duty_req = rows[r].duty;
      for (i = 0; i < 3000 && {inv, ratio} !== {rows[r].inv, rows[r].ratio};
           i++) @(negedge clock_in);
      check("ratio", {12'h0, inv, ratio},
            {12'h0, rows[r].inv, rows[r].ratio});
      n = 1 << (2 * rows[r].ratio);
      repeat (2 * n + 4) @(negedge clock_in);
      measure(4 * n);
      check("highs", highs, rows[r].high << 2);
      check("clamped highs", highs_both, rows[r].both << 2);
      $display("row %0d done", r);
    end
    // ==========================================================
    // Brief code excursion must never be accepted
    code_req = 4'h2;
    repeat (40) @(negedge clock_in);
    code_req = 4'h0;
    repeat (300) @(negedge clock_in);
    check("no excursion", {13'h0, ratio}, 16'h0);
    // Delta of two: accepted after 16*(2+6) periods, not earlier
    code_req = 4'h2;
    repeat (120) @(negedge clock_in);
    check("early accept", {13'h0, ratio}, 16'h0);
    repeat (20) @(negedge clock_in);
    check("late accept", {13'h0, ratio}, 16'h2);
    // Duty change mid-period must not cut a period short
    duty_req = 10'h0fa;
    repeat (36) @(negedge clock_in);
    measure(64);
    check("duty step", highs, 16'h0010);
    check("duty step clamped", highs_both, 16'h0010);
    $display("awkward cases done");
    // Second reset mid-run holds output low again; an inverted code
    // at full duty then shows the stretched first pulse
    code_req = 4'hd;
    duty_req = 10'h3e8;
    rst_in = 1'b1;
    @(negedge clock_in);
    check("reset again", {14'h0, pwm, started}, 16'h0);
    rst_in = 1'b0;
    measure(400);
    check("restart highs", highs, 16'h0);
    for (i = 0; i < 200 && started !== 1'b1; i++) @(negedge clock_in);
    check("restarted", {15'h0, started}, 16'h1);
    measure(24);
    check("first pulse", highs, 16'h0010);
    check("first pulse clamped", highs_both, 16'h0010);
    $display("reset case done");
    end_of_test();
  end
endmodule : test_divided_pwm_oscillator_core

// ===== verilog/divided_pwm_oscillator_core.sv
// Divided PWM oscillator core: code filter, glitchless divider, PWM.
// Assumes clock_in is the master oscillator and inputs are synchronous.
//
// How it works
// - Divide master clock by one of eight ratios
// - Take four-bit code from external converter
// - Code top bit selects inverted polarity
// - Invert modulated signal when polarity set
// - Duty linear in the duty command
// - Duty saturates beyond the control span
// - Unclamped variant rests low or high
// - Two-sided clamp keeps 5 to 95 percent; at ratio 1 the output rests low, or high for code 15
// - One-sided clamps allow one resting extreme
// - Inversion moves the one-sided clamp over
// - Changed code applied after sixteen times delta+6
// - Accept only stable codes, no intermediates
// - Ratio change happens without glitches
// - Output held low during start-up
// - Start-up lasts 500 master periods
// - Inverted first pulse at least quarter period
// - Start-up waits for a stable code
// - Codes 0/15 ratio 1, mirrored around midpoint
`timescale 1ns/1ns

module divided_pwm_oscillator_core #(
  parameter pwm_osc_pkg::clamp_variant_type CLAMP =
    pwm_osc_pkg::CLAMP_NONE
) (
  input  wire logic                                clock_in,
  input  wire logic                                rst_in,
  input  wire logic [pwm_osc_pkg::CODE_WIDTH-1:0]  divider_select_code_in,
  input  wire logic [pwm_osc_pkg::DUTY_WIDTH-1:0]  duty_command_in,
  output logic                                     pwm_out,
  output logic                                     output_invert_bit_out,
  output logic [2:0]                               ratio_select_out,
  output logic                                     started_out
);

  // ==========================================================
  // Sequencer
  typedef enum logic [1:0] {
    ST_START = 2'b01,
    ST_RUN   = 2'b10
  } phase_type;

  phase_type                               phase;
  logic [pwm_osc_pkg::CODE_WIDTH-1:0]      code_active;
  logic [pwm_osc_pkg::CODE_WIDTH-1:0]      code_cand;
  logic [pwm_osc_pkg::FILT_WIDTH-1:0]      filt_cnt;
  logic [pwm_osc_pkg::FILT_WIDTH-1:0]      filt_need;
  logic [pwm_osc_pkg::START_WIDTH-1:0]     start_cnt;
  logic [pwm_osc_pkg::CODE_WIDTH-1:0]      code_delta;
  logic                                    code_accept;
  pwm_osc_pkg::div_setting_type            setting;
  pwm_osc_pkg::div_setting_type            next_setting;
  logic [pwm_osc_pkg::CNT_WIDTH-1:0]       period_cnt;
  logic [pwm_osc_pkg::CNT_WIDTH-1:0]       period_last;
  logic [pwm_osc_pkg::CNT_WIDTH:0]         high_raw;
  logic [pwm_osc_pkg::CNT_WIDTH:0]         high_len;
  logic [pwm_osc_pkg::DUTY_WIDTH-1:0]      duty_clamped;
  logic [pwm_osc_pkg::DUTY_WIDTH-1:0]      duty_latched;
  logic                                    period_end;
  logic                                    first_pulse;
  logic                                    mod_level;

  localparam logic [pwm_osc_pkg::START_WIDTH-1:0] START_LAST =
    pwm_osc_pkg::START_WIDTH'(pwm_osc_pkg::STARTUP_COUNT - 1);

  // ==========================================================
  // Code decode: bit 3 inverts, lower bits mirror for codes >= 8
  always_comb begin
    next_setting.invert = code_cand[pwm_osc_pkg::INVERT_BIT];
    if (code_cand[pwm_osc_pkg::INVERT_BIT]) begin
      next_setting.ratio_sel = ~code_cand[2:0];
    end else begin
      next_setting.ratio_sel = code_cand[2:0];
    end
  end

  // Absolute code difference sets the filter wait
  always_comb begin
    if (code_cand > code_active) begin
      code_delta = code_cand - code_active;
    end else begin
      code_delta = code_active - code_cand;
    end
    filt_need = pwm_osc_pkg::FILT_SCALE *
                (pwm_osc_pkg::FILT_WIDTH'(code_delta) +
                 pwm_osc_pkg::FILT_BASE);
  end

  // ==========================================================
  // Code filter: candidate must hold still for the full wait.
  // A wobbling input restarts the count, so no passing code is taken.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      code_cand <= pwm_osc_pkg::CODE_RESET;
      filt_cnt  <= '0;
    end else if (divider_select_code_in != code_cand) begin
      code_cand <= divider_select_code_in;
      filt_cnt  <= '0;
    end else if (filt_cnt < filt_need) begin
      filt_cnt  <= filt_cnt + 1'b1;
    end
  end

  assign code_accept = (filt_cnt >= filt_need) &&
                       (divider_select_code_in == code_cand);

  // ==========================================================
  // Start-up: output low for 500 periods and until code settled
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      phase     <= ST_START;
      start_cnt <= '0;
    end else begin
      unique case (phase)
        ST_START: begin
          if (start_cnt != START_LAST) begin
            start_cnt <= start_cnt + 1'b1;
          end else if (code_accept) begin
            phase <= ST_RUN;
          end
        end
        ST_RUN: begin
          phase <= ST_RUN;
        end
      endcase
    end
  end

  // Active code: taken at start-up end, later only at period end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      code_active <= pwm_osc_pkg::CODE_RESET;
      setting     <= '0;
    end else if (code_accept &&
                 (phase == ST_START ? start_cnt == START_LAST
                                    : period_end)) begin
      code_active <= code_cand;
      setting     <= next_setting;
    end
  end

  // ==========================================================
  // Divider: last count is 4^n - 1, switched only at boundaries
  // Shift amount is widened first: ratio times step needs four bits
  assign period_last = pwm_osc_pkg::CNT_WIDTH'(
    (32'h1 << (5'(setting.ratio_sel) * 5'(pwm_osc_pkg::SHIFT_STEP))) - 32'h1);
  assign period_end  = (period_cnt >= period_last);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      period_cnt <= '0;
    end else if (phase != ST_RUN || period_end) begin
      period_cnt <= '0;
    end else begin
      period_cnt <= period_cnt + 1'b1;
    end
  end

  // ==========================================================
  // Duty clamp per variant; input beyond full scale saturates
  always_comb begin
    duty_clamped = (duty_command_in > pwm_osc_pkg::DUTY_FULL) ?
                   pwm_osc_pkg::DUTY_FULL : duty_command_in;
    unique case (CLAMP)
      pwm_osc_pkg::CLAMP_NONE: ;
      pwm_osc_pkg::CLAMP_BOTH: begin
        if (duty_clamped < pwm_osc_pkg::DUTY_LOW_CLMP)
          duty_clamped = pwm_osc_pkg::DUTY_LOW_CLMP;
        if (duty_clamped > pwm_osc_pkg::DUTY_HI_CLMP)
          duty_clamped = pwm_osc_pkg::DUTY_HI_CLMP;
      end
      pwm_osc_pkg::CLAMP_HIGH: begin
        if (duty_clamped > pwm_osc_pkg::DUTY_HI_CLMP)
          duty_clamped = pwm_osc_pkg::DUTY_HI_CLMP;
      end
      pwm_osc_pkg::CLAMP_LOW: begin
        if (duty_clamped < pwm_osc_pkg::DUTY_LOW_CLMP)
          duty_clamped = pwm_osc_pkg::DUTY_LOW_CLMP;
      end
    endcase
  end

  // Duty is latched at each period start so no period is cut short
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      duty_latched <= '0;
      first_pulse  <= 1'b1;
    end else if (phase != ST_RUN) begin
      duty_latched <= duty_clamped;
      first_pulse  <= 1'b1;
    end else if (period_end) begin
      duty_latched <= duty_clamped;
      first_pulse  <= 1'b0;
    end
  end

  // High time in master ticks: ratio * duty / full scale.
  // One bit wider than the counter so a full 16384 period fits.
  assign high_raw = (pwm_osc_pkg::CNT_WIDTH+1)'(
    ((32'(period_last) + 32'h1) * 32'(duty_latched)) /
    32'(pwm_osc_pkg::DUTY_FULL));

  // Clamped variants keep one tick of the clamped level per period
  // so the output never stops; divide by one cannot toggle at all,
  // a limit of pulse edges that sit on master clock edges
  localparam bit KEEP_HIGH_TICK = (CLAMP == pwm_osc_pkg::CLAMP_BOTH) ||
                                  (CLAMP == pwm_osc_pkg::CLAMP_LOW);
  localparam bit KEEP_LOW_TICK  = (CLAMP == pwm_osc_pkg::CLAMP_BOTH) ||
                                  (CLAMP == pwm_osc_pkg::CLAMP_HIGH);

  always_comb begin
    high_len = high_raw;
    if (KEEP_HIGH_TICK && period_last != '0 && high_raw == '0) begin
      high_len = {{pwm_osc_pkg::CNT_WIDTH{1'b0}}, 1'b1};
    end
    if (KEEP_LOW_TICK && period_last != '0 &&
        high_raw > {1'b0, period_last}) begin
      high_len = {1'b0, period_last};
    end
  end

  // ==========================================================
  // Output stage; held low through start-up.
  // Inversion applies after clamping, so clamps swap ends.
  // First inverted pulse: a high time under 25 % is stretched to the whole period.
  always_comb begin
    mod_level = (period_cnt < high_len);
    if (setting.invert && first_pulse &&
        duty_latched > (pwm_osc_pkg::DUTY_FULL -
                        pwm_osc_pkg::DUTY_QUARTER)) begin
      mod_level = 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pwm_out <= 1'b0;
    end else if (phase != ST_RUN) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= mod_level ^ setting.invert;
    end
  end

  assign output_invert_bit_out = setting.invert;
  assign ratio_select_out      = setting.ratio_sel;
  assign started_out           = (phase == ST_RUN);

  // ==========================================================
  // Assertions
  a_startup_low_out: assert property (@(posedge clock_in) disable iff
    (rst_in) !started_out |=> !pwm_out)
    else $error("output not low during start-up");

  a_startup_min_len: assert property (@(posedge clock_in) disable iff
    (rst_in) $rose(started_out) |-> start_cnt == START_LAST)
    else $error("start-up ended early");

  a_startup_stable: assert property (@(posedge clock_in) disable iff
    (rst_in) $rose(started_out) |-> $past(code_accept))
    else $error("start-up ended on unsettled code");

  a_polarity_bit: assert property (@(posedge clock_in) disable iff
    (rst_in) output_invert_bit_out == code_active[pwm_osc_pkg::INVERT_BIT])
    else $error("polarity not top code bit");

  a_setting_hold: assert property (@(posedge clock_in) disable iff
    (rst_in) started_out && !$past(period_end) |->
    $stable(setting))
    else $error("setting changed mid-period");

  a_code_unstable: assert property (@(posedge clock_in) disable iff
    (rst_in) divider_select_code_in != code_cand |=>
    $stable(code_active))
    else $error("unstable code accepted");

  a_ratio_mirror: assert property (@(posedge clock_in) disable iff
    (rst_in) code_active == 4'hf |-> ratio_select_out == 3'h0)
    else $error("code 15 not ratio one");

  a_clamp_both: assert property (@(posedge clock_in) disable iff
    (rst_in) CLAMP == pwm_osc_pkg::CLAMP_BOTH |->
    duty_clamped >= pwm_osc_pkg::DUTY_LOW_CLMP &&
    duty_clamped <= pwm_osc_pkg::DUTY_HI_CLMP)
    else $error("two-sided clamp violated");

  a_duty_saturate: assert property (@(posedge clock_in) disable iff
    (rst_in) duty_clamped <= pwm_osc_pkg::DUTY_FULL)
    else $error("duty beyond full scale");

  a_duty_period: assert property (@(posedge clock_in) disable iff
    (rst_in) started_out && !period_end |=> $stable(duty_latched))
    else $error("duty changed mid-period");

  a_rest_at_zero: assert property (@(posedge clock_in) disable iff
    (rst_in) started_out && duty_latched == '0 |=>
    pwm_out == $past(setting.invert))
    else $error("zero duty output not resting");

endmodule : divided_pwm_oscillator_core

// ===== verilog/pwm_osc_pkg.sv
// Package for the divided PWM oscillator core: constants and carriers.
// Assumes one master clock domain; analog front ends live outside.
package pwm_osc_pkg;

  // ==========================================================
  // Divider-select code
  localparam int          CODE_WIDTH    = 4;
  localparam int          INVERT_BIT    = 3;
  localparam logic [3:0]  CODE_RESET    = 4'h0;
  localparam int          NUM_RATIOS    = 8;
  localparam int          CNT_WIDTH     = 14;   // Up to divide by 16384
  localparam logic [2:0]  SHIFT_STEP    = 3'h2; // Ratio is 4 to the power n

  // ==========================================================
  // Code filter timing: 16 * (delta + 6) master periods
  localparam int          FILT_WIDTH    = 10;
  localparam logic [9:0]  FILT_SCALE    = 10'h010;
  localparam logic [9:0]  FILT_BASE     = 10'h006;

  // ==========================================================
  // Start-up interval in master clock periods
  localparam int          STARTUP_COUNT = 500;
  localparam int          START_WIDTH   = 9;

  // ==========================================================
  // Duty word: 0 means 0 %, DUTY_FULL means 100 %
  localparam int          DUTY_WIDTH    = 10;
  localparam logic [9:0]  DUTY_FULL     = 10'h3e8; // 1000 steps
  localparam logic [9:0]  DUTY_LOW_CLMP = 10'h032; // 5 %
  localparam logic [9:0]  DUTY_HI_CLMP  = 10'h3b6; // 95 %
  localparam logic [9:0]  DUTY_QUARTER  = 10'h0fa; // 25 %

  // Clamp variants
  typedef enum logic [1:0] {
    CLAMP_NONE = 2'h0,
    CLAMP_BOTH = 2'h1,
    CLAMP_HIGH = 2'h2,  // 0 % to 95 %
    CLAMP_LOW  = 2'h3   // 5 % to 100 %
  } clamp_variant_type;

  // Settings carried together once a code is accepted
  typedef struct packed {
    logic       invert;
    logic [2:0] ratio_sel;
  } div_setting_type;

endpackage : pwm_osc_pkg
